// ### ics_ctrl.v
// interrupt control and state register with wishbone slave and event interrupt
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ics_ctrl_regs.vh"

module ics_ctrl #(
  parameter PRI_W = 8
) (
  input  wire             mclk,
  input  wire             rst_n,
  // wishbone classic slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [3:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  input  wire             bus_nonsecure,
  // core state
  input  wire             nmi_in,
  input  wire             in_nmi_handler,
  input  wire             debug_state,
  input  wire             debug_flag,
  input  wire             irq_pend_ext,
  input  wire [8:0]       ext_pend_num,
  input  wire [PRI_W-1:0] ext_pend_pri,
  input  wire             ext_pend_is_fault,
  input  wire [PRI_W-1:0] svc_pri,
  input  wire [PRI_W-1:0] tick_pri,
  input  wire [PRI_W-1:0] base_priority_mask,
  input  wire             fault_mask_a,
  input  wire [8:0]       active_num,
  input  wire             preempted_active,
  input  wire             take_nmi,
  input  wire             take_svc_s,
  input  wire             take_svc_ns,
  input  wire             take_tick_s,
  input  wire             take_tick_ns,
  // exception pending state
  output reg              nmi_pending,
  output reg              svc_pend_s,
  output reg              svc_pend_ns,
  output reg              tick_pend_s,
  output reg              tick_pend_ns,
  output reg  [8:0]       highest_pending_number,
  output wire             irq_out
);

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  reg                     ack;
  reg  [`ICS_EV_W-1:0]    evt_stat;
  reg  [`ICS_EV_W-1:0]    evt_mask;
  reg                     ns_owns_nmi;
  reg                     nmi_prev;
  reg                     nmi_again;
  reg                     ret_base;
  reg  [8:0]              act_num;
  reg                     irq_pend_flag;

  wire req       = wb_cyc_i & wb_stb_i;
  // effects land on the edge the master sees ack
  wire fire      = req & ack;
  wire wr_fire   = fire & wb_we_i;
  wire sel_state = (wb_adr_i == `ICS_OFF_STATE);
  wire sel_stat  = (wb_adr_i == `ICS_OFF_EVT_STAT);
  wire sel_mask  = (wb_adr_i == `ICS_OFF_EVT_MASK);
  wire sel_ctrl  = (wb_adr_i == `ICS_OFF_CTRL);

  assign wb_ack_o = ack;

  // single wait state; ack drops the cycle after it was given
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ---------------------------------------------------------------------------
  // software set and clear strobes
  // ---------------------------------------------------------------------------
  wire wr_state = wr_fire & sel_state & wb_sel_i[3];
  wire nmi_acc  = ~bus_nonsecure | ns_owns_nmi;
  wire sw_nmi_set  = wr_state & nmi_acc & wb_dat_i[`ICS_NMI_SET];
  wire sw_nmi_clr  = wr_state & nmi_acc & wb_dat_i[`ICS_NMI_CLR];
  wire sw_svc_set  = wr_state & wb_dat_i[`ICS_SVC_SET];
  wire sw_svc_clr  = wr_state & wb_dat_i[`ICS_SVC_CLR];
  wire sw_tick_set = wr_state & wb_dat_i[`ICS_TICK_SET];
  wire sw_tick_clr = wr_state & wb_dat_i[`ICS_TICK_CLR];
  wire nmi_rise    = nmi_in & ~nmi_prev;

  // ---------------------------------------------------------------------------
  // pending state
  // ---------------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pending  <= 1'b0;
      nmi_prev     <= 1'b0;
      nmi_again    <= 1'b0;
      svc_pend_s   <= 1'b0;
      svc_pend_ns  <= 1'b0;
      tick_pend_s  <= 1'b0;
      tick_pend_ns <= 1'b0;
    end else begin
      nmi_prev <= nmi_in;
      // set wins over clear or exception entry
      if (sw_nmi_set | nmi_rise) begin
        nmi_pending <= 1'b1;
      end else if (sw_nmi_clr | take_nmi) begin
        nmi_pending <= 1'b0;
      end
      if (in_nmi_handler & nmi_rise) begin
        nmi_again <= 1'b1;
      end else if (!in_nmi_handler) begin
        nmi_again <= 1'b0;
      end
      if (sw_svc_set & ~bus_nonsecure) begin
        svc_pend_s <= 1'b1;
      end else if ((sw_svc_clr & ~bus_nonsecure) | take_svc_s) begin
        svc_pend_s <= 1'b0;
      end
      if (sw_svc_set & bus_nonsecure) begin
        svc_pend_ns <= 1'b1;
      end else if ((sw_svc_clr & bus_nonsecure) | take_svc_ns) begin
        svc_pend_ns <= 1'b0;
      end
      // banked tick set, shared tick clear
      if (sw_tick_set & ~bus_nonsecure) begin
        tick_pend_s <= 1'b1;
      end else if (sw_tick_clr | take_tick_s) begin
        tick_pend_s <= 1'b0;
      end
      if (sw_tick_set & bus_nonsecure) begin
        tick_pend_ns <= 1'b1;
      end else if (sw_tick_clr | take_tick_ns) begin
        tick_pend_ns <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // highest pending enabled exception
  // ---------------------------------------------------------------------------
  // a level of zero in the base mask disables it, as the core does
  // masks passed in, so every caller stays sensitive to them
  function masked;
    input [PRI_W-1:0] pri;
    input [PRI_W-1:0] base;
    input             fmask;
    begin
      masked = fmask | ((base != {PRI_W{1'b0}}) && (pri >= base));
    end
  endfunction

  wire ext_off  = masked(ext_pend_pri, base_priority_mask, fault_mask_a);
  wire svc_off  = masked(svc_pri, base_priority_mask, fault_mask_a);
  wire tick_off = masked(tick_pri, base_priority_mask, fault_mask_a);

  reg [8:0] best_num;
  reg [8:0] best_pri;

  // lower priority value wins; on a tie the external exception wins over svc, and svc over tick
  always @* begin
    best_num = `ICS_EXC_NONE;
    best_pri = `ICS_PRI_NONE;
    if (ext_pend_num != `ICS_EXC_NONE && (ext_pend_is_fault ? !fault_mask_a : !ext_off)) begin
      best_num = ext_pend_num;
      best_pri = {1'b0, ext_pend_pri};
    end
    if ((svc_pend_s | svc_pend_ns) && !svc_off && ({1'b0, svc_pri} < best_pri)) begin
      best_num = `ICS_EXC_SVC;
      best_pri = {1'b0, svc_pri};
    end
    if ((tick_pend_s | tick_pend_ns) && !tick_off &&
        ({1'b0, tick_pri} < best_pri)) begin
      best_num = `ICS_EXC_TICK;
      best_pri = {1'b0, tick_pri};
    end
    // nmi sits above every configurable level
    if (nmi_pending) begin
      best_num = `ICS_EXC_NMI;
      best_pri = `ICS_PRI_NONE;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      highest_pending_number <= `ICS_EXC_NONE;
      act_num                <= `ICS_EXC_NONE;
      ret_base               <= 1'b1;
      irq_pend_flag          <= 1'b0;
    end else begin
      highest_pending_number <= best_num;
      act_num                <= active_num;
      ret_base               <= ~preempted_active;
      irq_pend_flag          <= irq_pend_ext;
    end
  end

  // ---------------------------------------------------------------------------
  // read view of the state register
  // ---------------------------------------------------------------------------
  reg [31:0] state_view;
  always @* begin
    state_view = 32'h00000000;
    if (nmi_acc) begin
      state_view[`ICS_NMI_SET] = in_nmi_handler ? nmi_again : nmi_pending;
    end
    state_view[`ICS_SVC_SET]  = bus_nonsecure ? svc_pend_ns : svc_pend_s;
    state_view[`ICS_TICK_SET] = bus_nonsecure ? tick_pend_ns : tick_pend_s;
    state_view[`ICS_DEBUG_BIT] = debug_state & debug_flag;
    state_view[`ICS_IRQ_PEND]  = irq_pend_flag;
    state_view[`ICS_HPN_HI:`ICS_HPN_LO] = highest_pending_number;
    state_view[`ICS_RET_BASE]  = ret_base;
    state_view[`ICS_ACT_HI:`ICS_ACT_LO] = act_num;
  end

  // ---------------------------------------------------------------------------
  // event status, mask, control
  // ---------------------------------------------------------------------------
  wire [`ICS_EV_W-1:0] ev_in = {in_nmi_handler & nmi_rise, sw_tick_set, sw_svc_set, sw_nmi_set};
  wire                 wr_lo = wr_fire & wb_sel_i[0];
  wire [`ICS_EV_W-1:0] w1c   = (wr_lo & sel_stat) ? wb_dat_i[`ICS_EV_W-1:0]
                                                  : {`ICS_EV_W{1'b0}};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_stat    <= `ICS_EV_RST;
      evt_mask    <= `ICS_EV_RST;
      ns_owns_nmi <= `ICS_CTRL_RST;
    end else begin
      // a new event beats a clear in the same cycle
      evt_stat <= (evt_stat & ~w1c) | ev_in;
      if (wr_lo & sel_mask) begin
        evt_mask <= wb_dat_i[`ICS_EV_W-1:0];
      end
      // only secure software may hand nmi to the nonsecure side
      if (wr_lo & sel_ctrl & ~bus_nonsecure) begin
        ns_owns_nmi <= wb_dat_i[`ICS_CTRL_NS_NMI];
      end
    end
  end

  assign irq_out = |(evt_stat & evt_mask);

  // ---------------------------------------------------------------------------
  // read data, captured as ack rises
  // ---------------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req & ~ack & ~wb_we_i) begin
      case (wb_adr_i)
        `ICS_OFF_STATE:    wb_dat_o <= state_view;
        `ICS_OFF_EVT_STAT: wb_dat_o <= {28'h0000000, evt_stat};
        `ICS_OFF_EVT_MASK: wb_dat_o <= {28'h0000000, evt_mask};
        `ICS_OFF_CTRL:     wb_dat_o <= {31'h00000000, ns_owns_nmi};
        default:           wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // ics_ctrl
`default_nettype wire

// ### ics_ctrl_regs.vh
// register offsets, field positions and reset values of the interrupt control block
`ifndef ICS_CTRL_REGS_VH
`define ICS_CTRL_REGS_VH

// -----------------------------------------------------------------------------
// byte offsets (word aligned)
// -----------------------------------------------------------------------------
`define ICS_OFF_STATE      4'h0
`define ICS_OFF_EVT_STAT   4'h4
`define ICS_OFF_EVT_MASK   4'h8
`define ICS_OFF_CTRL       4'hC
`define ICS_ADDR_W         4

// -----------------------------------------------------------------------------
// interrupt_control_state fields
// -----------------------------------------------------------------------------
`define ICS_NMI_SET        31
`define ICS_NMI_CLR        30
`define ICS_SVC_SET        28
`define ICS_SVC_CLR        27
`define ICS_TICK_SET       26
`define ICS_TICK_CLR       25
`define ICS_TICK_TGT_NS    24
`define ICS_DEBUG_BIT      23
`define ICS_IRQ_PEND       22
`define ICS_HPN_HI         20
`define ICS_HPN_LO         12
`define ICS_RET_BASE       11
`define ICS_ACT_HI         8
`define ICS_ACT_LO         0

// -----------------------------------------------------------------------------
// exception numbers, event bits, control bits, reset values
// -----------------------------------------------------------------------------
`define ICS_EXC_NONE       9'h000
`define ICS_EXC_NMI        9'h002
`define ICS_EXC_SVC        9'h00E
`define ICS_EXC_TICK       9'h00F
`define ICS_PRI_NONE       9'h100
`define ICS_EV_NMI         0
`define ICS_EV_SVC         1
`define ICS_EV_TICK        2
`define ICS_EV_NMI_AGAIN   3
`define ICS_EV_W           4
`define ICS_CTRL_NS_NMI    0
`define ICS_EV_RST         4'h0
`define ICS_CTRL_RST       1'b0

`endif

// ### ics_ctrl_asserts.sv
// assertion checker of the interrupt control block, bound to its ports
`timescale 1ns/100ps
`default_nettype none
module ics_ctrl_asserts (
  input wire        mclk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        bus_nonsecure,
  input wire        nmi_in,
  input wire        debug_state,
  input wire        fault_mask_a,
  input wire        nmi_pending,
  input wire        svc_pend_s,
  input wire        svc_pend_ns,
  input wire        tick_pend_s,
  input wire        tick_pend_ns,
  input wire [8:0]  highest_pending_number
);
  // ---------------------------------------------------------------
  // accepted accesses to the state word
  // ---------------------------------------------------------------
  // pending bits live in the top byte, so writes count only with sel[3]
  wire acc = wb_cyc_i & wb_stb_i & wb_ack_o & (wb_adr_i == 4'h0);
  wire wr0 = acc & wb_we_i & wb_sel_i[3];
  wire ws  = wr0 & ~bus_nonsecure;
  wire wn  = wr0 & bus_nonsecure;
  wire rd0 = acc & ~wb_we_i;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_nmi_set: assert property (ws && wb_dat_i[31] |=> nmi_pending)
    else $error("nmi set write lost");
  a_nmi_clear: assert property (ws && wb_dat_i[30] && !wb_dat_i[31] && !nmi_in
    |=> !nmi_pending) else $error("nmi clear write lost");
  a_svc_bank: assert property (ws && wb_dat_i[28] && !svc_pend_ns
    |=> svc_pend_s && !svc_pend_ns) else $error("service call set in wrong bank");
  a_svc_clear: assert property (wn && wb_dat_i[27] && !wb_dat_i[28] |=> !svc_pend_ns)
    else $error("service call clear lost");
  a_tick_set: assert property (wn && wb_dat_i[26] |=> tick_pend_ns)
    else $error("tick set write lost");
  a_tick_clear: assert property (wr0 && wb_dat_i[25] && !wb_dat_i[26]
    |=> !tick_pend_s && !tick_pend_ns) else $error("tick clear missed a bank");
  a_rsvd_zero: assert property (rd0 |-> wb_dat_o[30:29] == 2'h0 &&
    wb_dat_o[25:24] == 2'h0 && !wb_dat_o[21]) else $error("reserved bit reads one");
  a_debug_zero: assert property (rd0 && !$past(debug_state) |-> !wb_dat_o[23])
    else $error("debug bit set outside debug");
  a_hpn_nmi: assert property (nmi_pending |=> highest_pending_number == 9'h002)
    else $error("pending nmi not reported highest");
  a_hpn_fmask: assert property (fault_mask_a && !nmi_pending
    |=> highest_pending_number == 9'h000) else $error("fault mask not applied");
endmodule // ics_ctrl_asserts
bind ics_ctrl ics_ctrl_asserts u_ics_ctrl_asserts (.*);
`default_nettype wire

// ### test_ics_ctrl.sv
// self-checking testbench of the interrupt control and state block
`timescale 1ns/100ps
`default_nettype none
module test_ics_ctrl;
  reg         mclk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
  reg         bus_nonsecure = 1'b0, nmi_in = 1'b0, in_nmi_handler = 1'b0;
  reg         debug_state = 1'b0, debug_flag = 1'b1, irq_pend_ext = 1'b0;
  reg         fault_mask_a = 1'b0, preempted_active = 1'b0;
  reg         take_nmi = 1'b0, take_svc_s = 1'b0, take_tick_ns = 1'b0;
  reg         ext_pend_is_fault = 1'b0;
  reg  [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  reg  [31:0] wb_dat_i = 32'h0, rq;
  reg  [8:0]  ext_pend_num = 9'h000, active_num = 9'h000;
  reg  [7:0]  ext_pend_pri = 8'h00, base_priority_mask = 8'h00;
  reg  [7:0]  svc_pri = 8'h10, tick_pri = 8'h20;
  wire        wb_stb_i = wb_cyc_i;
  wire        take_svc_ns = 1'b0, take_tick_s = 1'b0;
  wire [31:0] wb_dat_o;
  wire [8:0]  highest_pending_number;
  wire        wb_ack_o, nmi_pending, svc_pend_s, svc_pend_ns;
  wire        tick_pend_s, tick_pend_ns, irq_out;
  wire [7:0]  st = {2'h0, irq_out, nmi_pending, svc_pend_s, svc_pend_ns,
                    tick_pend_s, tick_pend_ns};
  integer     bad_count = 0, checked = 0, cycles = 0;

  ics_ctrl u_ics_ctrl (.*);

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  // ---------------------------------------------------------------
  // bus cycles and comparisons
  // ---------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cs(input [7:0] e);
    chk({24'h0, st}, {24'h0, e});
  endtask
  task ch(input [8:0] e);
    chk({23'h0, highest_pending_number}, {23'h0, e});
  endtask
  // one idle edge after ack also lets the registered pending number catch up
  task bus(input w, input [3:0] a, input [31:0] d, input n);
    begin
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      bus_nonsecure <= n;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1)
        @(posedge mclk);
      rq = wb_dat_o;
      wb_cyc_i <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input n);
    bus(1'b1, a, d, n);
  endtask
  task rc(input [3:0] a, input n, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0, n);
      chk(rq, e);
    end
  endtask
  task settle;
    repeat (2) @(posedge mclk);
  endtask
  task print_verdict;
    begin
      if (bad_count == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_map;
    integer i;
    begin
      wr(4'h0, 32'h2120_0000, 1'b0);
      wr(4'h2, 32'hFFFF_FFFF, 1'b0);
      for (i = 0; i < 16; i = i + 1)
        rc(i[3:0], 1'b0, (i == 0) ? 32'h0000_0800 : 32'h0);
    end
  endtask
  task t_nmi;
    begin
      wb_sel_i <= 4'h7;
      wr(4'h0, 32'h8000_0000, 1'b0);
      wb_sel_i <= 4'hF;
      rc(4'h0, 1'b0, 32'h0000_0800);
      wr(4'h0, 32'h8000_0000, 1'b0);
      rc(4'h0, 1'b0, 32'h8000_2800);
      cs(8'h10);
      wr(4'h8, 32'h0000_0001, 1'b0);
      cs(8'h30);
      wr(4'h4, 32'h0000_0001, 1'b0);
      cs(8'h10);
      wr(4'h0, 32'h4000_0000, 1'b0);
      rc(4'h0, 1'b0, 32'h0000_0800);
      wr(4'h8, 32'h0, 1'b0);
    end
  endtask
  task t_secure;
    begin
      wr(4'h0, 32'h8000_0000, 1'b1);
      cs(8'h00);
      wr(4'h0, 32'h8000_0000, 1'b0);
      rc(4'h0, 1'b1, 32'h0000_2800);
      wr(4'h0, 32'h4000_0000, 1'b1);
      cs(8'h10);
      wr(4'hC, 32'h0000_0001, 1'b1);
      rc(4'hC, 1'b0, 32'h0);
      wr(4'hC, 32'h0000_0001, 1'b0);
      rc(4'hC, 1'b0, 32'h0000_0001);
      wr(4'h0, 32'h4000_0000, 1'b1);
      cs(8'h00);
      wr(4'h0, 32'h8000_0000, 1'b1);
      rc(4'h0, 1'b1, 32'h8000_2800);
      wr(4'h0, 32'h4000_0000, 1'b1);
      wr(4'hC, 32'h0, 1'b0);
    end
  endtask
  task t_svc;
    begin
      wr(4'h0, 32'h1000_0000, 1'b0);
      cs(8'h08);
      rc(4'h0, 1'b1, 32'h0000_E800);
      rc(4'h0, 1'b0, 32'h1000_E800);
      take_svc_s <= 1'b1;
      @(posedge mclk);
      take_svc_s <= 1'b0;
      @(posedge mclk);
      cs(8'h00);
      wr(4'h0, 32'h1000_0000, 1'b1);
      cs(8'h04);
      wr(4'h0, 32'h0800_0000, 1'b0);
      cs(8'h04);
      wr(4'h0, 32'h0800_0000, 1'b1);
      cs(8'h00);
    end
  endtask
  task t_tick;
    begin
      wr(4'h0, 32'h0400_0000, 1'b1);
      rc(4'h0, 1'b1, 32'h0400_F800);
      wr(4'h0, 32'h0400_0000, 1'b0);
      cs(8'h03);
      take_tick_ns <= 1'b1;
      @(posedge mclk);
      take_tick_ns <= 1'b0;
      @(posedge mclk);
      cs(8'h02);
      wr(4'h0, 32'h0200_0000, 1'b1);
      cs(8'h00);
    end
  endtask
  task t_prio;
    begin
      wr(4'h0, 32'h1000_0000, 1'b0);
      base_priority_mask <= 8'h10;
      settle;
      ch(9'h000);
      base_priority_mask <= 8'h11;
      settle;
      ch(9'h00E);
      fault_mask_a <= 1'b1;
      settle;
      ch(9'h000);
      fault_mask_a <= 1'b0;
      ext_pend_num <= 9'h020;
      ext_pend_pri <= 8'h05;
      settle;
      ch(9'h020);
      ext_pend_pri <= 8'h30;
      settle;
      ch(9'h00E);
      // faults ignore the base mask, only the fault mask hides them
      base_priority_mask <= 8'h05;
      ext_pend_is_fault <= 1'b1;
      settle;
      ch(9'h020);
      ext_pend_is_fault <= 1'b0;
      ext_pend_num <= 9'h000;
      base_priority_mask <= 8'h00;
      wr(4'h0, 32'h0800_0000, 1'b0);
      settle;
      ch(9'h000);
    end
  endtask
  task t_fields;
    begin
      debug_state <= 1'b1;
      irq_pend_ext <= 1'b1;
      active_num <= 9'h00F;
      preempted_active <= 1'b1;
      settle;
      rc(4'h0, 1'b1, 32'h00C0_000F);
      debug_flag <= 1'b0;
      irq_pend_ext <= 1'b0;
      active_num <= 9'h000;
      preempted_active <= 1'b0;
      settle;
      rc(4'h0, 1'b0, 32'h0000_0800);
    end
  endtask
  task t_handler;
    begin
      nmi_in <= 1'b1;
      settle;
      cs(8'h10);
      take_nmi <= 1'b1;
      in_nmi_handler <= 1'b1;
      @(posedge mclk);
      take_nmi <= 1'b0;
      nmi_in <= 1'b0;
      settle;
      rc(4'h0, 1'b0, 32'h0000_0800);
      nmi_in <= 1'b1;
      settle;
      rc(4'h0, 1'b0, 32'h8000_2800);
      in_nmi_handler <= 1'b0;
      nmi_in <= 1'b0;
      wr(4'h0, 32'h4000_0000, 1'b0);
      cs(8'h00);
      rc(4'h4, 1'b0, 32'h0000_000F);
      wr(4'h8, 32'h0000_000F, 1'b0);
      cs(8'h20);
      wr(4'h4, 32'h0000_000F, 1'b0);
      cs(8'h00);
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_map;
    t_nmi;
    t_secure;
    t_svc;
    t_tick;
    t_prio;
    t_fields;
    t_handler;
    print_verdict;
  end
endmodule // test_ics_ctrl
`default_nettype wire
